// >>> dv/event_sys_model.sv
// Event system model: event lines, fault lines and overflow routing
`default_nettype none
module event_sys_model import tc_pkg::*; (
    // Clock
    input wire logic mclk,
    // Timer overflow
    input wire logic overflowEvt,
    // Event and fault lines
    output logic [NEV-1:0] events,
    output logic faultA,
    output logic faultB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NEV-1:0] lvl = '0;
    logic [NEV-1:0] pls = '0;
    logic cascade = 1'b0;
    int gap = 0;
    initial begin
        faultA = 1'b0;
        faultB = 1'b0;
    end
    // Overflow drives the top event line when cascaded
    assign events = lvl | pls | {cascade & overflowEvt, {(NEV-1){1'b0}}};
    // Width w high cycles, then gap + 1 idle cycles; slow partner widens gap
    task automatic pulse(input logic [NEV-1:0] m, input int w, input int n);
        repeat (n) begin
            pls <= m;
            repeat (w) @(posedge mclk);
            pls <= '0;
            repeat (gap + 1) @(posedge mclk);
        end
    endtask
    // Fault lines high for one cycle, with an optional event pulse alongside
    task automatic fault(input logic a, input logic b, input logic [NEV-1:0] m);
        faultA <= a;
        faultB <= b;
        pls <= m;
        @(posedge mclk);
        faultA <= 1'b0;
        faultB <= 1'b0;
        pls <= '0;
        @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_timer_counter_buffer_capture.sv
// Self-checking bench for the buffered timer/counter
`default_nettype none
module tb_timer_counter_buffer_capture import tc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [NEV-1:0] events;
    logic faultA;
    logic faultB;
    logic overflowEvt;
    logic errorEvt;
    int errors = 0;
    int n_checks = 0;
    int seed = 67484;
    int cycles = 0;
    int nOvf = 0;
    int nErr = 0;

    timer_counter_buffer_capture dut (.mclk(mclk), .reset(reset), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .events(events), .faultA(faultA), .faultB(faultB),
        .overflowEvt(overflowEvt), .errorEvt(errorEvt));
    event_sys_model evm (.mclk(mclk), .overflowEvt(overflowEvt), .events(events),
        .faultA(faultA), .faultB(faultB));

    initial begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (overflowEvt === 1'b1) nOvf <= nOvf + 1;
        if (errorEvt === 1'b1) nErr <= nErr + 1;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
        cmp(32'(hresp), 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        logic [31:0] q;
        rd(a, q);
        cmp(q & m, e);
    endtask
    task automatic do_reset();
        evm.lvl <= '0;
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [7:0] chv(input int i);
        return ADDR_CHAN + CHAN_STRIDE * 8'(i);
    endfunction
    function automatic logic [7:0] chb(input int i);
        return chv(i) + CHAN_BUF_OFS;
    endfunction
    function automatic logic [31:0] fb(input int f);
        return 32'h1 << f;
    endfunction
    function automatic logic [31:0] ctl(input logic [3:0] k, input logic [2:0] a,
            input logic [2:0] s, input logic [3:0] e, input logic [31:0] x);
        return x | 32'(k) << F_CLOCK_SOURCE_SELECT | 32'(a) << F_EVENT_ACTION_SELECT | 32'(s) << F_EVENT_SOURCE_SELECT
            | 32'(e) << F_CHEN;
    endfunction
    function automatic logic [15:0] step(input logic [15:0] c, input logic dn);
        if (dn) return (c == 16'h0) ? 16'h5 : c - 16'h1;
        return (c == 16'h5) ? 16'h0 : c + 16'h1;
    endfunction
    // Event clock on channel 0, period 2 cycles; model counts with period 5
    task automatic run(input int n, input logic dn, inout logic [15:0] c);
        evm.pulse(8'h1, 1, n);
        repeat (n) c = step(c, dn);
    endtask
    task automatic evcount(input logic [2:0] a, input logic [2:0] s);
        do_reset();
        wr(ADDR_CTRL, ctl(CLK_PER, a, s, 4'h0, 32'h0));
        evm.lvl <= 8'h1 << 3'(s + 3'h1);
        evm.pulse(8'h1 << s, a == EV_UPDOWN ? 6 : 1, a == EV_UPDOWN ? 1 : 6);
        evm.lvl <= 8'h0;
        evm.pulse(8'h1 << s, a == EV_UPDOWN ? 2 : 1, a == EV_UPDOWN ? 1 : 2);
        chk(ADDR_COUNT, 32'h4);
        $display("test event count done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [31:0] q;
        logic [15:0] c;
        logic [2:0] s;
        int o;
        do_reset();
        wr(8'h3C, $random(seed));
        for (int k = 0; k < 16; k++) begin
            chk(8'(k * 4), (k == 3 || k == 4) ? 32'hFFFF : 32'h0);
        end
        for (int i = 0; i < NCH; i++) begin
            d = $random(seed);
            wr(chv(i), d);
            wr(chb(i), ~d);
            chk(chv(i), {16'h0, d[15:0]});
            chk(chb(i), {16'h0, ~d[15:0]});
        end
        chk(ADDR_STATUS, 32'hF << S_BV, 32'hF << S_BV);
        $display("test registers done");
        do_reset();
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_COUNT, 32'h3);
        wr(ADDR_CTRL, ctl(4'h8, 3'h0, 3'h0, 4'h0, 32'h0));
        o = nOvf;
        c = 16'h3;
        run(4, 1'b0, c);
        chk(ADDR_COUNT, {16'h0, c});
        wr(ADDR_CTRL, ctl(4'h8, 3'h0, 3'h0, 4'h0, fb(F_DIR)));
        run(3, 1'b1, c);
        chk(ADDR_COUNT, {16'h0, c});
        cmp(32'(nOvf - o), 32'h2);
        wr(ADDR_CTRL, ctl(4'h8, 3'h0, 3'h0, 4'h0, 32'h0));
        wr(ADDR_COUNT, 32'hA);
        c = 16'hA;
        run(2, 1'b0, c);
        chk(ADDR_COUNT, {16'h0, c});
        $display("test counting done");
        do_reset();
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_CTRL, ctl(4'h8, 3'h0, 3'h0, 4'h0, fb(F_BUFEN)));
        wr(ADDR_PERIOD_BUFFER, 32'h7);
        wr(chb(1), 32'h55);
        c = 16'h0;
        run(5, 1'b0, c);
        chk(ADDR_PERIOD, 32'h5);
        d = fb(S_PBV) | fb(S_BV + 1);
        chk(ADDR_STATUS, d, d);
        run(1, 1'b0, c);
        chk(ADDR_PERIOD, 32'h7);
        chk(chv(1), 32'h55);
        chk(ADDR_STATUS, 32'h0, d);
        do_reset();
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_PERIOD_BUFFER, 32'h7);
        wr(chv(0), 32'h2);
        wr(chb(0), 32'h9);
        wr(ADDR_COUNT, 32'h5);
        wr(ADDR_CTRL, ctl(4'h8, 3'h0, 3'h0, 4'h0, fb(F_CIRC)));
        evm.pulse(8'h1, 1, 1);
        chk(ADDR_PERIOD, 32'h7);
        chk(ADDR_PERIOD_BUFFER, 32'h5);
        chk(chv(0), 32'h9);
        chk(chb(0), 32'h2);
        $display("test buffering done");
        evcount(EV_UPDOWN, 3'($random(seed)));
        evcount(EV_QDEC, 3'($random(seed)));
        do_reset();
        s = 3'($random(seed));
        wr(ADDR_CTRL, ctl(4'h0, EV_CAPT, s, 4'hF, fb(F_CAPMODE)));
        for (int i = 0; i < NCH; i++) begin
            c = 16'($random(seed));
            o = nErr;
            for (int k = 0; k < 3; k++) begin
                wr(ADDR_COUNT, {16'h0, c + 16'(k)});
                evm.pulse(8'h1 << 3'(s + 3'(i)), 1, 1);
            end
            chk(ADDR_STATUS, fb(S_IF + i) | fb(S_BV + i) | fb(S_ERR));
            cmp(32'(nErr - o), 32'h1);
            chk(chv(i), {16'h0, c});
            chk(ADDR_STATUS, fb(S_IF + i), fb(S_IF + i) | fb(S_BV + i));
            chk(chv(i), {16'h0, c + 16'h1});
        end
        d = fb(F_CAPMODE) | fb(F_DUAL_SLOPE_BOTH_UPDATE) | fb(F_FCAPA) | fb(F_FCAPB);
        wr(ADDR_CTRL, ctl(4'h0, EV_CAPT, s, 4'h3, d | fb(F_DIR)));
        wr(ADDR_COUNT, 32'h0123);
        evm.fault(1'b1, 1'b0, 8'h00);
        chk(chv(0), 32'h8123);
        wr(ADDR_CTRL, ctl(4'h0, EV_CAPT, s, 4'h3, d));
        wr(ADDR_COUNT, 32'h8123);
        evm.fault(1'b0, 1'b1, 8'h00);
        chk(chv(1), 32'h0123);
        // Undelayed fault stamps A; delayed event stamps B one count later
        wr(ADDR_CTRL, ctl(CLK_PER, EV_CAPT, s, 4'h3, fb(F_CAPMODE) | fb(F_FCAPA) | fb(F_EVDLY)));
        evm.fault(1'b1, 1'b0, 8'h1 << 3'(s + 3'h1));
        rd(chv(0), q);
        rd(chv(1), d);
        cmp(d - q, 32'h1);
        $display("test capture done");
        do_reset();
        wr(ADDR_CTRL, ctl(CLK_PER, EV_PWF, s, 4'h3, fb(F_CAPMODE)));
        evm.gap = 6;
        evm.pulse(8'h1 << s, 5, 2);
        evm.gap = 0;
        rd(chv(0), q);
        rd(chv(0), q);
        rd(chv(1), d);
        cmp(q - d, 32'h7);
        $display("test pulse width done");
        // Overflow routed back on event 7 triggers capture on channel A
        evm.cascade <= 1'b1;
        wr(ADDR_CTRL, ctl(CLK_PER, EV_CAPT, 3'h7, 4'h1, fb(F_CAPMODE)));
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_PERIOD, 32'h5);
        repeat (10) @(posedge mclk);
        chk(ADDR_STATUS, fb(S_IF), fb(S_IF));
        $display("test cascade done");
        close_out();
    end
endmodule
`default_nettype wire

// >>> rtl/ahb_reg_slave.sv
// AHB-Lite slave with one wait state on every transfer
`default_nettype none
module ahb_reg_slave import tc_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register side
    regbus_if.slave bus
);
    typedef enum logic {PH_IDLE = 1'b0, PH_DATA = 1'b1} phase_e;
    phase_e phase;
    logic isWrite;
    logic [AW-1:0] addrHold;
    wire accept = hsel & htrans[1] & hready;
    assign bus.wrEn = (phase == PH_DATA) & isWrite;
    assign bus.rdEn = (phase == PH_DATA) & ~isWrite;
    assign bus.addr = addrHold;
    assign bus.wdata = hwdata;

    always_ff @(posedge mclk) begin
        if (reset) begin
            phase <= PH_IDLE;
            isWrite <= 1'b0;
            addrHold <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (accept) begin
                        phase <= PH_DATA;
                        isWrite <= hwrite;
                        addrHold <= haddr[AW-1:0];
                        hreadyout <= 1'b0;
                    end
                end
                PH_DATA: begin
                    phase <= PH_IDLE;
                    hrdata <= isWrite ? 32'h00000000 : bus.rdata;
                    hreadyout <= 1'b1;
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtl/regbus_if.sv
// Internal register access bus between bus slave and register file
`default_nettype none
interface regbus_if;
    import tc_pkg::*;
    logic wrEn;
    logic rdEn;
    logic [AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave(output wrEn, rdEn, addr, wdata, input rdata);
    modport regs(input wrEn, rdEn, addr, wdata, output rdata);
endinterface
`default_nettype wire

// >>> rtl/tc_pkg.sv
// Constants, register map and event action codes of the timer/counter
`default_nettype none
package tc_pkg;
    localparam int DW = 16;
    localparam int NCH = 4;
    localparam int NEV = 8;
    localparam int AW = 8;
    // Register byte offsets
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [AW-1:0] ADDR_COUNT = 8'h08;
    localparam logic [AW-1:0] ADDR_PERIOD = 8'h0C;
    localparam logic [AW-1:0] ADDR_PERIOD_BUFFER = 8'h10;
    localparam logic [AW-1:0] ADDR_CHAN = 8'h14;
    localparam logic [AW-1:0] CHAN_STRIDE = 8'h08;
    localparam logic [AW-1:0] CHAN_BUF_OFS = 8'h04;
    // Control fields
    localparam int F_CLOCK_SOURCE_SELECT = 0;
    localparam int F_DIR = 4;
    localparam int F_BUFEN = 5;
    localparam int F_CIRC = 6;
    localparam int F_DUAL_SLOPE_BOTH_UPDATE = 7;
    localparam int F_CAPMODE = 8;
    localparam int F_CHEN = 9;
    localparam int F_EVENT_ACTION_SELECT = 13;
    localparam int F_EVENT_SOURCE_SELECT = 16;
    localparam int F_FCAPA = 19;
    localparam int F_FCAPB = 20;
    localparam int F_EVDLY = 21;
    localparam int CTRL_W = 22;
    // Status fields
    localparam int S_IF = 0;
    localparam int S_ERR = 4;
    localparam int S_OVF = 5;
    localparam int S_BV = 6;
    localparam int S_PBV = 10;
    // Clock source codes; bit 3 set selects event channel in bits 2:0
    localparam logic [3:0] CLK_PER = 4'h1;
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 22'h000000;
    localparam logic [DW-1:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [DW-1:0] ZERO_RESET = 16'h0000;
    typedef enum logic [2:0] {
        EV_NONE = 3'b000,
        EV_CAPT = 3'b001,
        EV_UPDOWN = 3'b010,
        EV_QDEC = 3'b011,
        EV_PWF = 3'b100
    } event_action_select_e;
endpackage
`default_nettype wire

// >>> rtl/timer_cc_channel.sv
// One compare/capture channel with its buffer and flags
`default_nettype none
module timer_cc_channel import tc_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Mode and timing
    input wire logic capMode,
    input wire logic circular,
    input wire logic update,
    input wire logic tick,
    input wire logic [DW-1:0] count,
    // Software access
    input wire logic wrVal,
    input wire logic wrBuf,
    input wire logic rdVal,
    input wire logic clrFlag,
    input wire logic [DW-1:0] wdata,
    // Capture
    input wire logic capEvent,
    input wire logic [DW-1:0] capData,
    // State
    output logic [DW-1:0] value,
    output logic [DW-1:0] buffer,
    output logic bufValid,
    output logic flag,
    output logic overflow
);
    wire full = bufValid & flag;
    wire capTake = capMode & capEvent & ~full;
    wire moveUp = capMode & bufValid & (~flag | rdVal);
    wire cmpLoad = ~capMode & update & (circular | bufValid);
    wire match = ~capMode & tick & (count == value);
    wire [DW-1:0] next_value = wrVal ? wdata : (moveUp | cmpLoad) ? buffer : value; // R03 R05
    wire [DW-1:0] next_buffer = wrBuf ? wdata : capTake ? capData // R05 R17
                                : (cmpLoad & circular) ? value : buffer; // R02
    wire next_bufValid = (wrBuf & ~capMode) | capTake // R01 R18
                         | (bufValid & ~(moveUp | (~capMode & update))); // R01
    wire next_flag = moveUp | match | (flag & ~clrFlag & ~(capMode & rdVal)); // R04

    always_ff @(posedge mclk) begin
        if (reset) begin
            value <= ZERO_RESET;
            buffer <= ZERO_RESET;
            bufValid <= 1'b0;
            flag <= 1'b0;
            overflow <= 1'b0;
        end else begin
            value <= next_value;
            buffer <= next_buffer;
            bufValid <= next_bufValid;
            flag <= next_flag;
            overflow <= capMode & capEvent & full; // R22
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_OVF_DISCARD: assert property (capMode && capEvent && full && !wrBuf // R22
        |=> overflow && buffer == $past(buffer)) else $error("overflow not flagged");
    AST_FIFO_MOVE: assert property (capMode && bufValid && !flag && !wrVal // R03
        |=> flag && value == $past(buffer)) else $error("buffer not moved");
    AST_BV_SET: assert property (!capMode && wrBuf |=> bufValid) // R01
        else $error("buffer valid not set");
    AST_CIRC_SWAP: assert property (!capMode && update && circular && !wrVal && !wrBuf // R02
        |=> value == $past(buffer) && buffer == $past(value)) else $error("no swap");
    COV_OVF: cover property (capMode && capEvent && full);
    COV_MOVE: cover property (moveUp && rdVal);
endmodule
`default_nettype wire

// >>> rtl/timer_counter_buffer_capture.sv
// 16-bit timer/counter with buffered period and capture channels
//
// Functional notes
// (R01) Compare use: buffer write sets buffer valid, update clears it.
// (R02) Circular option swaps period and channel A with buffers on update.
// (R03) Capture buffer and channel value act as two-entry FIFO.
// (R04) Moving buffered capture into value sets the channel flag.
// (R05) Software reads and writes channel value and buffer directly.
// (R06) Counter steps per timer clock; up at top loads zero.
// (R07) Down at bottom reloads period value.
// (R08) Software counter write wins over count, clear and reload.
// (R09) Direction may change while counting.
// (R10) Up/down action: event n gates, event n+1 selects up.
// (R11) Quadrature action counts by decoded event pulses.
// (R12) Cascade: low counter overflow event clocks high counter.
// (R13) Unbuffered period write is immediate; counter may wrap past it.
// (R14) Buffered period loads from period buffer only on update.
// (R15) Event source n captures channel A, n+1 channel B, onward.
// (R16) Fault capture options trigger capture on channel A or B.
// (R17) Enabled channels copy counter value as timestamp.
// (R18) Input capture sets channel flag; buffer valid marks buffer data.
// (R19) Capture msb holds direction when dual slope both, else counter msb.
// (R20) Pulse-width action: rise captures A and restarts, fall captures B.
// (R21) High counter of a 32-bit pair delays capture event one clock.
// (R22) Capture into full channel is discarded and sets error flag.
// (R23) Update is signalled at bottom or top per direction.
// (R24) Bottom is zero; top is period value.
`default_nettype none
module timer_counter_buffer_capture import tc_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event system and fault extension
    input wire logic [NEV-1:0] events,
    input wire logic faultA,
    input wire logic faultB,
    // Events out
    output logic overflowEvt,
    output logic errorEvt
);
    ////////////////////////////////////////////////////////////////////
    regbus_if bus();

    ahb_reg_slave uSlave (
        .mclk(mclk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .bus(bus)
    );

    function automatic logic hitChan(input logic [AW-1:0] a, input int i, input logic isBuf);
        logic [AW-1:0] ofs;
        ofs = AW'(ADDR_CHAN + CHAN_STRIDE * i) + (isBuf ? CHAN_BUF_OFS : 8'h00);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [CTRL_W-1:0] ctrl;
    logic [DW-1:0] cnt;
    logic [DW-1:0] period;
    logic [DW-1:0] period_buffer;
    logic perBv;
    logic ovfFlag;
    logic errFlag;
    logic [NEV-1:0] evPrev;
    logic pwPrev;

    wire [DW-1:0] wd = bus.wdata[DW-1:0];
    wire ctrlWr = bus.wrEn & (bus.addr == ADDR_CTRL);
    wire statWr = bus.wrEn & (bus.addr == ADDR_STATUS);
    wire cntWr = bus.wrEn & (bus.addr == ADDR_COUNT);
    wire perWr = bus.wrEn & (bus.addr == ADDR_PERIOD);
    wire perBufWr = bus.wrEn & (bus.addr == ADDR_PERIOD_BUFFER);

    // Control fields
    wire [3:0] clock_source_select = ctrl[F_CLOCK_SOURCE_SELECT +: 4];
    wire dirDown = ctrl[F_DIR];
    wire bufEn = ctrl[F_BUFEN];
    wire circ = ctrl[F_CIRC];
    wire dual_slope_both_update = ctrl[F_DUAL_SLOPE_BOTH_UPDATE];
    wire capMode = ctrl[F_CAPMODE];
    wire [NCH-1:0] chEn = ctrl[F_CHEN +: NCH];
    wire [2:0] event_source_select = ctrl[F_EVENT_SOURCE_SELECT +: 3];
    event_action_select_e event_action_select;
    assign event_action_select = event_action_select_e'(ctrl[F_EVENT_ACTION_SELECT +: 3]);

    ////////////////////////////////////////////////////////////////////
    // Event selection and counter stepping
    wire [NEV-1:0] evIn = ctrl[F_EVDLY] ? evPrev : events; // R21
    wire evN = evIn[event_source_select];
    wire evN1 = evIn[event_source_select + 3'd1];
    wire clkTick = (clock_source_select == CLK_PER) | (clock_source_select[3] & evIn[clock_source_select[2:0]]);
    wire isUd = (event_action_select == EV_UPDOWN);
    wire isQd = (event_action_select == EV_QDEC);
    wire countUp = (isUd | isQd) ? evN1 : ~dirDown; // R09 R10 R11
    wire tick = isQd ? evN : isUd ? (clkTick & evN) : clkTick; // R10 R11
    wire pwRise = (event_action_select == EV_PWF) & evN & ~pwPrev;
    wire pwFall = (event_action_select == EV_PWF) & ~evN & pwPrev;
    wire atTop = (cnt == period); // R13 R24
    wire atBot = (cnt == ZERO_RESET); // R24
    wire update = tick & (countUp ? atTop : atBot); // R23
    wire [DW-1:0] stepped = countUp ? (atTop ? ZERO_RESET : cnt + 16'h0001) // R06
                                    : (atBot ? period : cnt - 16'h0001); // R07
    wire [DW-1:0] next_cnt = cntWr ? wd : pwRise ? ZERO_RESET // R08 R20
                             : tick ? stepped : cnt;

    ////////////////////////////////////////////////////////////////////
    // Period with optional buffering and circular swap
    wire perLoad = update & (circ | (bufEn & perBv));
    wire [DW-1:0] next_period = perWr ? wd : perLoad ? period_buffer : period; // R13 R14 R02
    wire [DW-1:0] next_period_buffer = perBufWr ? wd : (update & circ) ? period : period_buffer; // R02
    wire next_perBv = perBufWr | (perBv & ~update); // R01

    ////////////////////////////////////////////////////////////////////
    // Capture channels
    logic [DW-1:0] chVal [NCH];
    logic [DW-1:0] chBuf [NCH];
    logic [NCH-1:0] chBv;
    logic [NCH-1:0] chIf;
    logic [NCH-1:0] chErr;
    logic [NCH-1:0] capEv;
    logic [31:0] chRd [NCH];
    wire [DW-1:0] capData = {dual_slope_both_update ? ~countUp : cnt[DW-1], cnt[DW-2:0]}; // R19

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : gCh
            wire hitV = hitChan(bus.addr, i, 1'b0);
            wire hitB = hitChan(bus.addr, i, 1'b1);
            wire evCap = (event_action_select == EV_CAPT) & evIn[event_source_select + 3'(i)]; // R15 R18
            wire pwCap = (i == 0) ? pwRise : (i == 1) ? pwFall : 1'b0; // R20
            wire fCap = (i == 0) ? (ctrl[F_FCAPA] & faultA) // R16
                        : (i == 1) ? (ctrl[F_FCAPB] & faultB) : 1'b0;
            assign capEv[i] = chEn[i] & (evCap | pwCap | fCap); // R17
            assign chRd[i] = hitV ? {16'h0000, chVal[i]}
                             : hitB ? {16'h0000, chBuf[i]} : 32'h00000000;

            timer_cc_channel uCh (
                .mclk(mclk),
                .reset(reset),
                .capMode(capMode),
                .circular((i == 0) & circ),
                .update(update),
                .tick(tick),
                .count(cnt),
                .wrVal(bus.wrEn & hitV),
                .wrBuf(bus.wrEn & hitB),
                .rdVal(bus.rdEn & hitV),
                .clrFlag(statWr & bus.wdata[S_IF + i]),
                .wdata(wd),
                .capEvent(capEv[i]),
                .capData(capData),
                .value(chVal[i]),
                .buffer(chBuf[i]),
                .bufValid(chBv[i]),
                .flag(chIf[i]),
                .overflow(chErr[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Read data
    wire [10:0] status = {perBv, chBv, ovfFlag, errFlag, chIf};
    logic [31:0] chRdAll;
    always_comb begin
        chRdAll = 32'h00000000;
        for (int k = 0; k < NCH; k++) begin
            chRdAll = chRdAll | chRd[k];
        end
    end
    assign bus.rdata = (bus.addr == ADDR_CTRL) ? {10'h000, ctrl}
                     : (bus.addr == ADDR_STATUS) ? {21'h000000, status}
                     : (bus.addr == ADDR_COUNT) ? {16'h0000, cnt}
                     : (bus.addr == ADDR_PERIOD) ? {16'h0000, period}
                     : (bus.addr == ADDR_PERIOD_BUFFER) ? {16'h0000, period_buffer}
                     : chRdAll;

    ////////////////////////////////////////////////////////////////////
    // Sticky status, set wins over clear
    wire next_ovf = update | (ovfFlag & ~(statWr & bus.wdata[S_OVF]));
    wire next_err = (|chErr) | (errFlag & ~(statWr & bus.wdata[S_ERR])); // R22

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            cnt <= ZERO_RESET;
            period <= PERIOD_RESET;
            period_buffer <= PERIOD_RESET;
            perBv <= 1'b0;
            ovfFlag <= 1'b0;
            errFlag <= 1'b0;
            evPrev <= 8'h00;
            pwPrev <= 1'b0;
            overflowEvt <= 1'b0;
            errorEvt <= 1'b0;
        end else begin
            if (ctrlWr) begin
                ctrl <= bus.wdata[CTRL_W-1:0];
            end
            cnt <= next_cnt;
            period <= next_period;
            period_buffer <= next_period_buffer;
            perBv <= next_perBv;
            ovfFlag <= next_ovf;
            errFlag <= next_err;
            evPrev <= events;
            pwPrev <= evN;
            overflowEvt <= update; // R12
            errorEvt <= |chErr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_CNT_WRITE: assert property (cntWr |=> cnt == $past(wd)) // R08
        else $error("counter write lost");
    AST_UP_WRAP: assert property (tick && countUp && atTop && !cntWr && !pwRise // R06
        |=> cnt == 16'h0000) else $error("no wrap to zero");
    AST_DOWN_RELOAD: assert property (tick && !countUp && atBot && !cntWr && !pwRise // R07
        && !perWr |=> cnt == $past(period)) else $error("no reload");
    AST_PER_BUF_LOAD: assert property (update && bufEn && perBv && !circ && !perWr // R14
        && !perBufWr |=> period == $past(period_buffer) && !perBv) else $error("period not loaded");
    AST_PER_HOLD: assert property (!update && !perWr |=> $stable(period)) // R14
        else $error("period changed outside update");
    AST_UD_GATE: assert property (isUd && !evN && !cntWr |=> $stable(cnt)) // R10
        else $error("count without gate");
    AST_PW_RESTART: assert property (pwRise && !cntWr |=> cnt == 16'h0000) // R20
        else $error("no restart");
    AST_UPDATE_EVT: assert property (update |=> overflowEvt && ovfFlag) // R23
        else $error("update not signalled");
    AST_ERR_FLAG: assert property (|chErr |=> errFlag && errorEvt) // R22
        else $error("error flag missing");

    COV_WRAP: cover property (tick && countUp && atTop);
    COV_PW: cover property (pwRise ##[1:50] pwFall);
    COV_BUFLOAD: cover property (perLoad && bufEn);
endmodule
`default_nettype wire
